//--- rtl/rsol_strap_latch.sv
`timescale 1ns/1ps
module rsol_strap_latch (
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire logic [rsol_pkg::PIN_N-1:0] pin_i,
  input  wire logic [2:0]                 proc_id_i,
  input  wire logic [rsol_pkg::PIN_N-1:0] func_o,
  input  wire logic [rsol_pkg::PIN_N-1:0] func_oe,
  output logic [rsol_pkg::PIN_N-1:0]      func_i,
  output rsol_pkg::rsol_pad_s             pad,
  output rsol_pkg::rsol_cfg_s             strap_cfg,
  output logic                            irq_edge_mode,
  output logic                            straps_valid,
  output logic [31:0]                     system_config_register,
  output logic [31:0]                     sdram_config_register,
  input  wire logic                       hsel,
  input  wire logic [7:0]                 haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp
);
  import rsol_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // no reset on these: they must carry the pin level through reset
  logic [PIN_N-1:0] pin_s1_q;
  logic [PIN_N-1:0] pin_s2_q;
  logic [2:0]       id_s1_q;
  logic [2:0]       id_s2_q;

  always_ff @(posedge clock) begin
    pin_s1_q <= pin_i;
    pin_s2_q <= pin_s1_q;
    id_s1_q  <= proc_id_i;
    id_s2_q  <= id_s1_q;
  end

  always_ff @(posedge clock) begin
    func_i <= pin_s2_q;
  end

  // ---------------------------------------------------------------
  // reset phase sequencer
  // ---------------------------------------------------------------
  rsol_phase_e phase_q;
  logic [1:0]  settle_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_q  <= RSOL_PH_RESET;
      settle_q <= 2'h0;
    end else begin
      case (phase_q)
        RSOL_PH_RESET: begin
          phase_q  <= RSOL_PH_SETTLE;
          settle_q <= 2'h1;
        end
        // wait out the synchroniser so the sample is the release-edge level
        RSOL_PH_SETTLE: begin
          if (settle_q == SETTLE_CYC) begin
            phase_q <= RSOL_PH_RUN;
          end else begin
            settle_q <= settle_q + 2'h1;
          end
        end
        RSOL_PH_RUN: begin
          phase_q <= RSOL_PH_RUN;
        end
        default: begin
          phase_q <= RSOL_PH_RESET;
        end
      endcase
    end
  end

  logic run;
  logic capture;
  assign run     = (phase_q == RSOL_PH_RUN);
  assign capture = (phase_q == RSOL_PH_SETTLE) && (settle_q == SETTLE_CYC);

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_cfg     <= CFG_RST;
      irq_edge_mode <= 1'b0;
      straps_valid  <= 1'b0;
    end else if (capture) begin
      strap_cfg.boot_wait        <= pin_s2_q[PIN_BOOT];
      strap_cfg.irq_enable       <= pin_s2_q[PIN_IRQ];
      irq_edge_mode              <= pin_s2_q[PIN_IRQ];
      strap_cfg.link_width4      <= pin_s2_q[PIN_LINK];
      strap_cfg.cfg_write_always <= pin_s2_q[PIN_CFGW];
      strap_cfg.test_mode        <= pin_s2_q[PIN_TMA+2:PIN_TMA];
      straps_valid               <= 1'b1;
    end
  end
  // no other load path: values stay until arst_n falls again

  // ---------------------------------------------------------------
  // pad control
  // ---------------------------------------------------------------
  // pulls are not under async reset: id-gating needs the sampled id,
  // so pull-downs settle three clocks into reset, pull-ups one
  logic             id_zero;
  logic [PIN_N-1:0] id_gate;
  logic [PIN_N-1:0] pad_pd_q;
  logic [PIN_N-1:0] pad_pu_q;
  logic [PIN_N-1:0] pad_o_q;
  logic [PIN_N-1:0] pad_oe_q;
  assign id_zero = (id_s2_q == PROC_ID_ZERO);
  assign id_gate = id_zero ? {PIN_N{1'b1}} : ~ID_DEP_MASK;

  always_ff @(posedge clock) begin
    if (!run) begin
      pad_pd_q <= PD_RESET_MASK & id_gate;
      pad_pu_q <= PU_RESET_MASK;
    end else begin
      pad_pd_q <= {PIN_N{1'b0}};
      pad_pu_q <= ID_DEP_MASK & id_gate;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pad_oe_q <= {PIN_N{1'b0}};
      pad_o_q  <= {PIN_N{1'b0}};
    end else begin
      pad_o_q  <= func_o;
      pad_oe_q <= run ? func_oe : {PIN_N{1'b0}};
    end
  end

  // two processes feed the pad struct, so it is packed from flops here
  assign pad = '{o: pad_o_q, oe: pad_oe_q, pu: pad_pu_q, pd: pad_pd_q};

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] addr_q;
  logic       sys_lock_q;
  logic       sdr_lock_q;
  logic       accept;

  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);

  function automatic logic [31:0] status_word(input rsol_cfg_s c, input logic r,
                                              input logic ls, input logic ld);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ST_CFG_LSB +: 7]  = c;
    w[ST_RUN_BIT]       = r;
    w[ST_SYS_LOCK_BIT]  = ls;
    w[ST_SDR_LOCK_BIT]  = ld;
    return w;
  endfunction

  function automatic logic may_write(input logic always_wr, input logic lock);
    return always_wr || !lock;
  endfunction

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      if (accept) begin
        wr_pend_q <= hwrite;
        rd_pend_q <= !hwrite;
        addr_q    <= {haddr[7:2], 2'h0};
      end else if (hreadyout) begin
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
      end
    end
  end

  // reads take one wait state so a write just before is seen
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_q && !hreadyout) begin
        hreadyout <= 1'b1;
        case (addr_q)
          ADDR_STATUS:    hrdata <= status_word(strap_cfg, run, sys_lock_q, sdr_lock_q);
          ADDR_SYS_CFG:   hrdata <= system_config_register;
          ADDR_SDRAM_CFG: hrdata <= sdram_config_register;
          default:        hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  logic wr_sys;
  logic wr_sdr;
  assign wr_sys = wr_pend_q && run && (addr_q == ADDR_SYS_CFG)
                  && may_write(strap_cfg.cfg_write_always, sys_lock_q);
  assign wr_sdr = wr_pend_q && run && (addr_q == ADDR_SDRAM_CFG)
                  && may_write(strap_cfg.cfg_write_always, sdr_lock_q);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      system_config_register <= SYS_CFG_RST;
      sys_lock_q             <= 1'b0;
    end else if (wr_sys) begin
      system_config_register <= hwdata;
      sys_lock_q             <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sdram_config_register <= SDRAM_CFG_RST;
      sdr_lock_q            <= 1'b0;
    end else if (wr_sdr) begin
      sdram_config_register <= hwdata;
      sdr_lock_q            <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_release;
    phase_q == RSOL_PH_SETTLE ##1 phase_q == RSOL_PH_RUN;
  endsequence

  sequence s_run_two;
    run ##1 run;
  endsequence

  chk_capture_value: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_release |-> strap_cfg.boot_wait == $past(pin_s2_q[PIN_BOOT], 1)
                  && straps_valid)
    else $error("strap value not caught at release");

  chk_capture_hold: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_run_two |-> $stable(strap_cfg) && straps_valid)
    else $error("latched strap changed after capture");

  chk_release_time: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(phase_q == RSOL_PH_SETTLE) |-> ##2 run)
    else $error("pins not returned to function in time");

  chk_reset_float: assert property (
    @(posedge clock) disable iff (!arst_n)
    !run |=> pad.oe == {PIN_N{1'b0}})
    else $error("strap pin driven during reset");

  chk_reset_pulls: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!run ##1 !run) |-> pad.pu[PIN_TMA+2:PIN_TMA] == 3'h7
                        && pad.pd[PIN_LINK:PIN_IRQ] == 2'h3)
    else $error("default strap pulls missing");

  chk_id_pulls: assert property (
    @(posedge clock) disable iff (!arst_n)
    $past(!id_zero) && $past(!run) |-> (pad.pd & ID_DEP_MASK) == 7'h00)
    else $error("id-dependent pull on nonzero id");

  chk_run_pullup: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_run_two ##0 $past(id_zero) |-> pad.pu == ID_DEP_MASK && pad.pd == 7'h00)
    else $error("pull-down not turned to pull-up");

  chk_irq_mode: assert property (
    @(posedge clock) disable iff (!arst_n)
    straps_valid |-> irq_edge_mode == strap_cfg.irq_enable)
    else $error("irq enable and edge mode disagree");

  chk_driven_pins: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_run_two |-> pad.oe == $past(func_oe, 1))
    else $error("driven pin enable not following function");

  chk_write_once: assert property (
    @(posedge clock) disable iff (!arst_n)
    sys_lock_q && !strap_cfg.cfg_write_always |=> $stable(system_config_register))
    else $error("locked system config was rewritten");

  chk_write_always: assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_pend_q && run && addr_q == ADDR_SDRAM_CFG && strap_cfg.cfg_write_always
    |=> sdram_config_register == $past(hwdata, 1))
    else $error("always-writable sdram config not written");

  chk_read_wait: assert property (
    @(posedge clock) disable iff (!arst_n)
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer not after one wait state");

  chk_capture_rest: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_release |-> strap_cfg.link_width4 == $past(pin_s2_q[PIN_LINK], 1)
                  && strap_cfg.cfg_write_always == $past(pin_s2_q[PIN_CFGW], 1)
                  && strap_cfg.test_mode == $past(pin_s2_q[PIN_TMA+2:PIN_TMA], 1))
    else $error("link, write or test strap not caught at release");

  chk_irq_capture: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_release |-> irq_edge_mode == $past(pin_s2_q[PIN_IRQ], 1)
                  && strap_cfg.irq_enable == $past(pin_s2_q[PIN_IRQ], 1))
    else $error("irq strap not caught at release");

  chk_sdr_once: assert property (
    @(posedge clock) disable iff (!arst_n)
    sdr_lock_q && !strap_cfg.cfg_write_always |=> $stable(sdram_config_register))
    else $error("locked sdram config was rewritten");

  chk_early_drop: assert property (
    @(posedge clock) disable iff (!arst_n)
    !run |=> $stable(system_config_register) && $stable(sdram_config_register))
    else $error("config written before straps were caught");

  chk_func_in: assert property (
    @(posedge clock) disable iff (!arst_n)
    straps_valid |-> func_i == $past(pin_i, 3))
    else $error("pin level not passed to function input");

  chk_valid_run: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(run) |-> straps_valid && $past(!straps_valid, 1))
    else $error("straps not flagged valid as pins are released");

  chk_run_nopull: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_run_two ##0 $past(!id_zero) |-> pad.pu == 7'h00 && pad.pd == 7'h00)
    else $error("id-dependent pull left on nonzero id");

endmodule // rsol_strap_latch

//--- pkg/rsol_pkg.sv
// Notes on behaviour
// - straps are caught at the release of reset and held as configuration
// - strap pins return to their normal functions shortly after reset release
// - an undriven strap pin yields the default set by its internal pull
// - boot strap 0 boots from boot memory, 1 idles awaiting external boot
// - interrupt strap 0 leaves irqs off and level; 1 enables them edge-sensitive
// - link width strap 0 selects 1-bit receive, 1 selects 4-bit
// - config write strap 0 makes system and sdram config write-once; 1 always
// - pull or drive state of each strap pin follows reset low or high
// - id-dependent pulls only on processor id zero; pull-down becomes pull-up
// - defaults: pull-downs on four option straps, pull-ups on test straps
package rsol_pkg;

  localparam int PIN_N = 7;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SETTLE_CYC = 2'h2;

  // pin order: boot select, interrupt, link width, config write, test a, b, c
  localparam int PIN_BOOT = 0;
  localparam int PIN_IRQ = 1;
  localparam int PIN_LINK = 2;
  localparam int PIN_CFGW = 3;
  localparam int PIN_TMA = 4;

  localparam logic [6:0] PD_RESET_MASK = 7'h0F;
  localparam logic [6:0] PU_RESET_MASK = 7'h70;
  localparam logic [6:0] ID_DEP_MASK = 7'h09;
  localparam logic [6:0] DRIVEN_MASK = 7'h76;
  localparam logic [2:0] PROC_ID_ZERO = 3'h0;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SYS_CFG = 8'h04;
  localparam logic [7:0] ADDR_SDRAM_CFG = 8'h08;
  localparam logic [31:0] SYS_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SDRAM_CFG_RST = 32'h0000_0000;

  localparam int ST_CFG_LSB = 0;
  localparam int ST_RUN_BIT = 8;
  localparam int ST_SYS_LOCK_BIT = 9;
  localparam int ST_SDR_LOCK_BIT = 10;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    RSOL_PH_RESET  = 3'b001,
    RSOL_PH_SETTLE = 3'b010,
    RSOL_PH_RUN    = 3'b100
  } rsol_phase_e;

  typedef struct packed {
    logic [2:0] test_mode;
    logic       cfg_write_always;
    logic       link_width4;
    logic       irq_enable;
    logic       boot_wait;
  } rsol_cfg_s;

  localparam rsol_cfg_s CFG_RST = '{test_mode: 3'h7, default: 1'b0};

  typedef struct packed {
    logic [PIN_N-1:0] o;
    logic [PIN_N-1:0] oe;
    logic [PIN_N-1:0] pu;
    logic [PIN_N-1:0] pd;
  } rsol_pad_s;

endpackage

//--- tb/rsol_board_model.sv
`timescale 1ns/1ps
module rsol_board_model (
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire rsol_pkg::rsol_pad_s pad,
  input  wire logic [6:0]          ext_val,
  input  wire logic [6:0]          ext_en,
  output logic [6:0]               pin
);
  import rsol_pkg::*;
  logic [6:0] ext_ok;
  logic [6:0] float_q = 7'h00;
  // ----------------------------------------
  // board straps and loads
  // ----------------------------------------
  // test straps are never overdriven while reset is low
  assign ext_ok = arst_n ? ext_en : (ext_en & ~PU_RESET_MASK);
  // an unpulled, undriven pin wanders so a missing pull shows up
  always_ff @(posedge clock) begin
    float_q <= ~pin;
  end
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      if (pad.oe[i] === 1'b1) pin[i] = pad.o[i];
      else if (ext_ok[i]) pin[i] = ext_val[i];
      else if (pad.pu[i] === 1'b1) pin[i] = 1'b1;
      else if (pad.pd[i] === 1'b1) pin[i] = 1'b0;
      else pin[i] = float_q[i];
    end
  end
endmodule // rsol_board_model

//--- tb/reset_strap_option_latch_tb.sv
`timescale 1ns/1ps
module reset_strap_option_latch_tb;
  import rsol_pkg::*;
  logic        clock = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hreadyout, hresp, irq_edge_mode, straps_valid;
  logic [2:0]  proc_id = 3'h0;
  logic [6:0]  ext_val = 7'h00, ext_en = 7'h00, func_o = 7'h00, func_oe = 7'h00;
  logic [6:0]  pin, func_i;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd, sys_reg, sdr_reg;
  rsol_pad_s   pad;
  rsol_cfg_s   strap_cfg;
  int          failures = 0, total_checks = 0, cycles = 0;

  rsol_board_model u_board (.clock(clock), .arst_n(arst_n), .pad(pad), .ext_val(ext_val),
    .ext_en(ext_en), .pin(pin));
  rsol_strap_latch u_dut (.clock(clock), .arst_n(arst_n), .pin_i(pin), .proc_id_i(proc_id),
    .func_o(func_o), .func_oe(func_oe), .func_i(func_i), .pad(pad), .strap_cfg(strap_cfg),
    .irq_edge_mode(irq_edge_mode), .straps_valid(straps_valid),
    .system_config_register(sys_reg), .sdram_config_register(sdr_reg), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  initial begin
    forever #2 clock = ~clock;
  end
  // hang guard, well above the hundred or so cycles the scenarios need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic enter_reset(input logic [2:0] id, input logic [6:0] v, input logic [6:0] e);
    arst_n <= 1'b0;
    proc_id <= id;
    ext_val <= v;
    ext_en <= e;
    func_oe <= 7'h00;
    repeat (6) @(posedge clock);
    check("valid_in_reset", {31'h0, straps_valid}, 32'h0);
    check("oe_in_reset", {25'h0, pad.oe}, 32'h0);
    check("pu_in_reset", {25'h0, pad.pu}, {25'h0, PU_RESET_MASK});
  endtask
  task automatic wait_valid;
    for (int i = 0; i < 20 && straps_valid !== 1'b1; i++) @(posedge clock);
    check("straps_valid", {31'h0, straps_valid}, 32'h1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_defaults;
    enter_reset(3'h0, 7'h00, 7'h00);
    check("pd_id0", {25'h0, pad.pd}, 32'h0F);
    arst_n <= 1'b1;
    ahb(1'b1, ADDR_SYS_CFG, 32'hA5A5_0001);
    wait_valid();
    check("cfg_default", {25'h0, strap_cfg}, {25'h0, CFG_RST});
    check("cfg_default_val", {25'h0, strap_cfg}, 32'h70);
    check("irq_mode_level", {31'h0, irq_edge_mode}, 32'h0);
    ahb(1'b0, ADDR_SYS_CFG, 32'h0);
    check("early_write", rd, 32'h0);
    check("pu_run_id0", {25'h0, pad.pu}, 32'h09);
    check("pd_run", {25'h0, pad.pd}, 32'h0);
    func_oe <= 7'h55;
    func_o <= 7'h7F;
    repeat (2) @(posedge clock);
    check("oe_function", {25'h0, pad.oe}, 32'h55);
    check("o_function", {25'h0, pad.o}, 32'h7F);
    repeat (3) @(posedge clock);
    check("func_in", {25'h0, func_i & 7'h55}, 32'h55);
    ahb(1'b1, ADDR_SYS_CFG, 32'h1111_1111);
    ahb(1'b1, ADDR_SYS_CFG, 32'h2222_2222);
    ahb(1'b1, ADDR_SDRAM_CFG, 32'h3333_3333);
    ahb(1'b1, ADDR_SDRAM_CFG, 32'h4444_4444);
    ahb(1'b0, ADDR_SYS_CFG, 32'h0);
    check("sys_once", rd, 32'h1111_1111);
    ahb(1'b0, ADDR_SDRAM_CFG, 32'h0);
    check("sdram_once", rd, 32'h3333_3333);
    check("sys_reg_out", sys_reg, 32'h1111_1111);
    check("sdr_reg_out", sdr_reg, 32'h3333_3333);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd, 32'h0000_0770);
    ahb(1'b0, 8'h0C, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask
  task automatic sc_strapped;
    enter_reset(3'h0, 7'h0F, 7'h0F);
    arst_n <= 1'b1;
    wait_valid();
    check("cfg_all_set", {25'h0, strap_cfg}, 32'h7F);
    check("irq_mode_edge", {31'h0, irq_edge_mode}, 32'h1);
    ext_val <= 7'h00;
    repeat (10) @(posedge clock);
    check("cfg_held", {25'h0, strap_cfg}, 32'h7F);
    ahb(1'b1, ADDR_SYS_CFG, 32'h5555_0001);
    ahb(1'b1, ADDR_SYS_CFG, 32'h5555_0002);
    ahb(1'b1, ADDR_SDRAM_CFG, 32'h6666_0001);
    ahb(1'b1, ADDR_SDRAM_CFG, 32'h6666_0002);
    ahb(1'b0, ADDR_SYS_CFG, 32'h0);
    check("sys_always", rd, 32'h5555_0002);
    check("sys_reg_always", sys_reg, 32'h5555_0002);
    check("sdr_reg_always", sdr_reg, 32'h6666_0002);
  endtask
  task automatic sc_other_id;
    enter_reset(3'h5, 7'h05, 7'h0F);
    check("pd_id5", {25'h0, pad.pd}, 32'h06);
    arst_n <= 1'b1;
    wait_valid();
    check("cfg_mixed", {25'h0, strap_cfg}, 32'h75);
    repeat (2) @(posedge clock);
    check("pu_run_id5", {25'h0, pad.pu}, 32'h0);
  endtask

  initial begin
    @(posedge clock);
    sc_defaults();
    sc_strapped();
    sc_other_id();
    final_report();
  end
endmodule // reset_strap_option_latch_tb
